// >>> rsc_reset_ctrl.sv
// Reset source controller: sequencer, cause flags, APB registers and interrupt.
//
// Overview of operation
// - Reset halts core, reloads registers, disables interrupts.
// - Reset keeps data memory, reloads stack pointer; the code has no stack pointer output and only blocks memory writes.
// - Port latches all ones, open drain, pull-ups.
// - Drive reset pin low for power resets.
// - Leaving reset clears PC, selects internal clock.
// - Leaving reset enables watchdog, clock divided twelve.
// - Every reset starts fetching at address zero.
// - Hold until supply good, then release delay.
// - Power-on exit sets the power-on flag.
// - Other resets clear power-on flag.
// - Power-on leaves supply monitor enabled.
// - Writing one to pin flag forces power-on.
// - Leaving a pin reset sets the pin flag.
// - Missing clock resets, flags; write sets enable.
// - Supply below threshold holds reset, drives pin.
//
// The implementer's own choices: the register addresses and register access over APB.
module rsc_reset_ctrl
    import rsc_pkg::*;
#(
    parameter int POR_DELAY_CYCLES   = POR_DELAY_CYC,
    parameter int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // APB slave port.
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // Supply monitor, reset pin and monitored system clock.
    input  wire logic              supply_ok_in,
    input  wire logic              reset_pin_n_in,
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe_out,
    input  wire logic              sys_clk_in,
    // Port pad defaults.
    input  wire logic [7:0]        port_data_in,
    input  wire logic              port_od_in,
    input  wire logic              pullup_req_in,
    output logic [7:0]             port_latch_out,
    output logic                   port_od_out,
    output logic                   pullup_en_out,
    // Chip-wide reset controls.
    output logic                   core_reset_out,
    output logic                   ram_write_block_out,
    output logic                   pc_load_out,
    output logic [15:0]            fetch_addr_out,
    output logic                   sysclk_sel_out,
    output logic                   wdt_enable_out,
    output logic [3:0]             wdt_div_out,
    output logic                   vdd_mon_en_out,
    output logic                   irq_out
);

    rsc_state_t       state;               // Current sequencer state.
    rsc_state_t       next_state;          // Sequencer state for the next edge.
    rsc_cause_t       cause;               // Cause of the reset in progress.
    rsc_cause_t       next_cause;          // Cause for the next edge.
    logic             delay_done;          // Release delay has run out.
    logic             mcd_timeout;         // No system clock edge in time.
    logic             sys_clk_q;           // Previous sample of the system clock.
    logic             mcd_en;              // Missing clock detector enable.
    logic             power_on_flag;       // Last reset was a power-on reset.
    logic             pin_reset_flag;      // Last reset came from the pin.
    logic             missing_clock_flag;  // Last reset came from the detector.
    logic [IRQ_W-1:0] irq_status;          // Sticky event bits.
    logic [IRQ_W-1:0] irq_enable;          // Event mask.
    logic [IRQ_W-1:0] irq_set;             // Events of this cycle.
    logic [IRQ_W-1:0] irq_clear;           // Software clear of this cycle.
    logic             access;              // APB access phase completes now.
    logic             wr_en;               // Completed write to a mapped register.
    logic             sw_force;            // Software forces a power-on reset.
    logic             exit_reset;          // Reset ends at the coming edge.
    logic             in_reset_next;       // Reset is active after the coming edge.
    logic [31:0]      rd_data;             // Read value for the current address.

    // Tells whether an address hits one of the registers.
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_RESET_SOURCE) || (a == ADDR_CONTROL) ||
               (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_CLEAR) ||
               (a == ADDR_IRQ_ENABLE);
    endfunction

    assign access        = psel_in & penable_in & pready_out;
    assign wr_en         = access & pwrite_in & addr_mapped(paddr_in);
    assign sw_force      = wr_en && (paddr_in == ADDR_RESET_SOURCE) &&
                           pwdata_in[BIT_PIN] && (state == RSC_RUN);
    assign exit_reset    = (state != RSC_RUN) && (next_state == RSC_RUN);
    assign in_reset_next = (next_state != RSC_RUN);

    // Power-on release delay starts afresh each time the delay state is entered.
    rsc_timer #(
        .COUNT (POR_DELAY_CYCLES)
    ) u_delay (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .restart_in  (state != RSC_DELAY),
        .expired_out (delay_done)
    );

    // Clock watch restarts on each rising system clock edge while enabled.
    rsc_timer #(
        .COUNT (MCD_TIMEOUT_CYCLES)
    ) u_mcd (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .restart_in  (!mcd_en || (state != RSC_RUN) || (sys_clk_in && !sys_clk_q)),
        .expired_out (mcd_timeout)
    );

    // Keeps the previous system clock sample for edge detection.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sys_clk_q <= 1'b0;
        end else begin
            sys_clk_q <= sys_clk_in;
        end
    end

    // Chooses the next state; software force outranks supply, pin and clock.
    always_comb begin
        next_state = state;
        next_cause = cause;
        case (state)
            RSC_RUN: begin
                if (sw_force) begin
                    next_state = RSC_SUPPLY;
                    next_cause = CAUSE_POR;
                end else if (vdd_mon_en_out && !supply_ok_in) begin
                    next_state = RSC_SUPPLY;
                    next_cause = CAUSE_SUPPLY;
                end else if (!reset_pin_n_in) begin
                    next_state = RSC_PIN;
                    next_cause = CAUSE_PIN;
                end else if (mcd_timeout) begin
                    next_state = RSC_MCD;
                    next_cause = CAUSE_MCD;
                end
            end
            RSC_SUPPLY: begin
                if (supply_ok_in) begin
                    next_state = RSC_DELAY;
                end
            end
            RSC_DELAY: begin
                if (!supply_ok_in) begin
                    next_state = RSC_SUPPLY;
                end else if (delay_done) begin
                    next_state = RSC_RUN;
                end
            end
            RSC_PIN: begin
                if (vdd_mon_en_out && !supply_ok_in) begin
                    next_state = RSC_SUPPLY;
                    next_cause = CAUSE_SUPPLY;
                end else if (reset_pin_n_in) begin
                    next_state = RSC_RUN;
                end
            end
            RSC_MCD: begin
                next_state = RSC_RUN;  // One-cycle internal reset, pin untouched.
            end
            default: begin
                next_state = RSC_SUPPLY;
                next_cause = CAUSE_POR;
            end
        endcase
    end

    // Sequencer state and cause registers; power-up enters as a power-on reset.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= RSC_SUPPLY;
            cause <= CAUSE_POR;
        end else begin
            state <= next_state;
            cause <= next_cause;
        end
    end

    // Reset outputs switch together from the next state, so release is one edge.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            core_reset_out      <= 1'b1;
            ram_write_block_out <= 1'b1;
            reset_pin_oe_out    <= 1'b1;
            reset_pin_out       <= PIN_DRIVE_LVL;
        end else begin
            core_reset_out      <= in_reset_next;
            ram_write_block_out <= in_reset_next;
            reset_pin_oe_out    <= (next_state == RSC_SUPPLY) ||
                                   (next_state == RSC_DELAY);
            reset_pin_out       <= PIN_DRIVE_LVL;
        end
    end

    // Port pads take their safe defaults while reset lasts.
    always_ff @(posedge clk_in) begin
        if (rst_in || in_reset_next) begin
            port_latch_out <= PORT_RESET_VAL;
            port_od_out    <= 1'b1;
            pullup_en_out  <= 1'b1;
        end else begin
            port_latch_out <= port_data_in;
            port_od_out    <= port_od_in;
            pullup_en_out  <= pullup_req_in;
        end
    end

    // Program counter load pulse and entry address at release.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pc_load_out    <= 1'b0;
            fetch_addr_out <= ENTRY_ADDR;
            wdt_div_out    <= WDT_DIV;
        end else begin
            pc_load_out    <= exit_reset;
            fetch_addr_out <= ENTRY_ADDR;
            wdt_div_out    <= WDT_DIV;
        end
    end

    // Cause flags are written once, on the edge that ends the reset.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            power_on_flag      <= 1'b0;
            pin_reset_flag     <= 1'b0;
            missing_clock_flag <= 1'b0;
        end else if (exit_reset) begin
            power_on_flag      <= (cause == CAUSE_POR);
            pin_reset_flag     <= (cause == CAUSE_PIN);
            missing_clock_flag <= (cause == CAUSE_MCD);
        end
    end

    // Control bits take reset values in reset (supply monitor enable only for a power-on cause) and software values afterwards.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            vdd_mon_en_out <= 1'b1;
            sysclk_sel_out <= CLK_INTERNAL;
            wdt_enable_out <= 1'b1;
            mcd_en         <= MCD_EN_RESET;
        end else if (state != RSC_RUN) begin
            sysclk_sel_out <= CLK_INTERNAL;
            wdt_enable_out <= 1'b1;
            mcd_en         <= MCD_EN_RESET;
            if (cause == CAUSE_POR) begin
                vdd_mon_en_out <= 1'b1;
            end
        end else if (wr_en && (paddr_in == ADDR_RESET_SOURCE)) begin
            mcd_en <= pwdata_in[BIT_MCD];
        end else if (wr_en && (paddr_in == ADDR_CONTROL)) begin
            vdd_mon_en_out <= pwdata_in[CTL_VDM];
            sysclk_sel_out <= pwdata_in[CTL_CLK];
            wdt_enable_out <= pwdata_in[CTL_WDT];
        end
    end

    // Events of this cycle for the interrupt status register.
    always_comb begin
        irq_set             = '0;
        irq_set[IRQ_PIN]    = exit_reset && (cause == CAUSE_PIN);
        irq_set[IRQ_POR]    = exit_reset && (cause == CAUSE_POR);
        irq_set[IRQ_MCD]    = exit_reset && (cause == CAUSE_MCD);
        irq_set[IRQ_SUPPLY] = (next_state == RSC_SUPPLY) &&
                              (next_cause == CAUSE_SUPPLY) &&
                              ((state == RSC_RUN) || (state == RSC_PIN));
        irq_clear           = '0;
        if (wr_en && (paddr_in == ADDR_IRQ_CLEAR)) begin
            irq_clear = pwdata_in[IRQ_W-1:0];
        end
    end

    // Sticky status, where an event beats a clear in the same cycle.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end

    // Interrupt mask is cleared from the edge that enters reset until release.
    always_ff @(posedge clk_in) begin
        if (rst_in || in_reset_next || (state != RSC_RUN)) begin
            irq_enable <= '0;
        end else if (wr_en && (paddr_in == ADDR_IRQ_ENABLE)) begin
            irq_enable <= pwdata_in[IRQ_W-1:0];
        end
    end

    // Level interrupt while any enabled status bit is set, held off during reset.
    always_ff @(posedge clk_in) begin
        if (rst_in || in_reset_next) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status & irq_enable);
        end
    end

    // Read multiplexer; clear register and unmapped addresses read zero.
    always_comb begin
        rd_data = '0;
        case (paddr_in)
            ADDR_RESET_SOURCE: begin
                rd_data[BIT_PIN] = pin_reset_flag;
                rd_data[BIT_POR] = power_on_flag;
                rd_data[BIT_MCD] = missing_clock_flag;
            end
            ADDR_CONTROL: begin
                rd_data[CTL_VDM] = vdd_mon_en_out;
                rd_data[CTL_CLK] = sysclk_sel_out;
                rd_data[CTL_WDT] = wdt_enable_out;
                rd_data[CTL_MCD] = mcd_en;
            end
            ADDR_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_ENABLE: rd_data[IRQ_W-1:0] = irq_enable;
            default: rd_data = '0;
        endcase
    end

    // APB answer: ready in the first access cycle, error on unmapped address.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else if (psel_in && !penable_in) begin
            pready_out  <= 1'b1;
            pslverr_out <= !addr_mapped(paddr_in);
            prdata_out  <= rd_data;
        end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end
    end

    // Counts consecutive cycles spent in the release delay, for checking only.
    int dly_cycles;
    always_ff @(posedge clk_in) begin
        if (rst_in || (state != RSC_DELAY)) begin
            dly_cycles <= 0;
        end else begin
            dly_cycles <= dly_cycles + 1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // A software force in the current cycle; the property checks the supply wait that follows.
    sequence sw_force_s;
        sw_force;
    endsequence
    sequence mcd_trip_s;
        (state == RSC_MCD) ##1 (state == RSC_RUN);
    endsequence

    core_hold_a: assert property (core_reset_out |-> ram_write_block_out && !irq_out)
        else $error("core reset without memory guard or with interrupt");
    ram_guard_a: assert property ((state != RSC_RUN) |-> ram_write_block_out)
        else $error("memory writes open during reset");
    port_safe_a: assert property (core_reset_out |->
                                  port_latch_out == PORT_RESET_VAL && port_od_out && pullup_en_out)
        else $error("ports not in reset state");
    pin_drive_a: assert property (((state == RSC_SUPPLY) || (state == RSC_DELAY)) |->
                                  reset_pin_oe_out && (reset_pin_out == PIN_DRIVE_LVL))
        else $error("reset pin not driven during power reset");
    exit_clock_a: assert property ($fell(core_reset_out) |->
                                   pc_load_out && (sysclk_sel_out == CLK_INTERNAL))
        else $error("release without pc load or internal clock");
    exit_wdt_a: assert property ($fell(core_reset_out) |->
                                 wdt_enable_out && (wdt_div_out == WDT_DIV))
        else $error("watchdog not enabled at release");
    entry_addr_a: assert property (pc_load_out |-> (fetch_addr_out == ENTRY_ADDR))
        else $error("entry address not zero");
    por_delay_a: assert property (((state == RSC_RUN) && ($past(state) == RSC_DELAY)) |->
                                  (dly_cycles > POR_DELAY_CYCLES))
        else $error("release delay too short");
    por_flag_a: assert property ((exit_reset && (cause == CAUSE_POR)) |=>
                                 power_on_flag && (state == RSC_RUN))
        else $error("power-on flag not set on exit");
    por_clear_a: assert property ((exit_reset && (cause != CAUSE_POR)) |=> !power_on_flag)
        else $error("power-on flag kept after other reset");
    vdm_on_a: assert property ((exit_reset && (cause == CAUSE_POR)) |=> vdd_mon_en_out)
        else $error("supply monitor off after power-on");
    sw_por_a: assert property (sw_force_s |=> (state == RSC_SUPPLY) && (cause == CAUSE_POR)
                               ##1 reset_pin_oe_out)
        else $error("software force did not start power-on reset");
    pin_flag_a: assert property ((exit_reset && (cause == CAUSE_PIN)) |=> pin_reset_flag)
        else $error("pin flag not set on exit");
    mcd_flag_a: assert property (mcd_trip_s |-> missing_clock_flag && !reset_pin_oe_out)
        else $error("missing clock reset flag or pin wrong");
    supply_hold_a: assert property (((state == RSC_RUN) && vdd_mon_en_out && !supply_ok_in
                                    && !sw_force) |=> (state == RSC_SUPPLY) && reset_pin_oe_out)
        else $error("supply drop did not hold reset");
    sync_rel_a: assert property ($fell(core_reset_out) |-> $fell(ram_write_block_out))
        else $error("reset outputs released on different edges");
    apb_ready_a: assert property ((psel_in && !penable_in) |=> pready_out ##1 !pready_out)
        else $error("apb ready timing wrong");

endmodule

// >>> rsc_pkg.sv
// Shared constants, register map and types of the reset source controller.
package rsc_pkg;

    // Clock and timing figures.
    localparam int CLK_PERIOD_NS   = 40;      // Controller clock period in ns.
    localparam int POR_DELAY_NS    = 300000;  // Power-on release delay, 0.3 ms.
    localparam int MCD_TIMEOUT_NS  = 100000;  // Missing clock timeout, 100 us.
    // Each delay rounds down to whole cycles, never below one.
    localparam int POR_DELAY_CYC   = (POR_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     POR_DELAY_NS / CLK_PERIOD_NS;
    localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     MCD_TIMEOUT_NS / CLK_PERIOD_NS;

    // Register byte addresses on the APB port.
    localparam int         ADDR_W             = 8;
    localparam logic [7:0] ADDR_RESET_SOURCE  = 8'h00;
    localparam logic [7:0] ADDR_CONTROL       = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h10;

    // Bit positions in the reset source register.
    localparam int BIT_PIN = 0;  // Pin reset flag, write one forces power-on reset.
    localparam int BIT_POR = 1;  // Power-on flag, read only.
    localparam int BIT_MCD = 2;  // Missing clock flag, write sets detector enable.

    // Bit positions in the control register.
    localparam int CTL_VDM = 0;  // Supply monitor enable.
    localparam int CTL_CLK = 1;  // System clock source select.
    localparam int CTL_WDT = 2;  // Watchdog enable.
    localparam int CTL_MCD = 3;  // Missing clock detector enable, read only.

    // Interrupt status bits.
    localparam int IRQ_W      = 4;
    localparam int IRQ_PIN    = 0;  // Left a pin reset.
    localparam int IRQ_POR    = 1;  // Left a power-on reset.
    localparam int IRQ_MCD    = 2;  // Left a missing clock reset.
    localparam int IRQ_SUPPLY = 3;  // Supply dropped below threshold.

    // Reset values and fixed levels.
    localparam logic [7:0]  PORT_RESET_VAL = 8'hFF;   // Port latches in reset.
    localparam logic [15:0] ENTRY_ADDR     = 16'h0000; // First fetch address.
    localparam logic [3:0]  WDT_DIV        = 4'hC;    // Watchdog clock divider.
    localparam logic        CLK_INTERNAL   = 1'b0;    // Internal oscillator select.
    localparam logic        PIN_DRIVE_LVL  = 1'b0;    // Level driven on reset pin.
    localparam logic        MCD_EN_RESET   = 1'b1;    // Detector enable after reset.

    // Reset sequencer states.
    typedef enum logic [2:0] {
        RSC_SUPPLY,  // Waiting for supply above threshold.
        RSC_DELAY,   // Power-on release delay running.
        RSC_PIN,     // External pin holds reset.
        RSC_MCD,     // Missing clock reset pulse.
        RSC_RUN      // Chip out of reset.
    } rsc_state_t;

    // Cause of the reset in progress.
    typedef enum logic [1:0] {
        CAUSE_POR,
        CAUSE_SUPPLY,
        CAUSE_PIN,
        CAUSE_MCD
    } rsc_cause_t;

endpackage

// >>> rsc_timer.sv
// Restartable one-shot cycle timer used for release delay and clock watch.
module rsc_timer #(
    parameter int COUNT = 7500,
    localparam int W    = $clog2(COUNT + 1)
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic restart_in,
    output logic      expired_out
);

    localparam logic [W-1:0] LAST = W'(COUNT - 1);  // Final count before expiry.

    logic [W-1:0] count;  // Cycles elapsed since the last restart.

    // Counts clock edges after restart and flags expiry after COUNT edges.
    always_ff @(posedge clk_in) begin
        if (rst_in || restart_in) begin
            count       <= '0;
            expired_out <= 1'b0;
        end else if (!expired_out) begin
            if (count == LAST) begin
                expired_out <= 1'b1;
            end else begin
                count <= count + W'(1);
            end
        end
    end

endmodule

// >>> rsc_far_side.sv
// Far side model: supply monitor, external reset circuit and system clock.
module rsc_far_side (
    input  wire logic supply_req_in,
    input  wire logic pin_low_in,
    input  wire logic clk_stop_in,
    input  wire logic pin_oe_in,
    output logic      supply_ok_out,
    output logic      pin_n_out,
    output logic      sys_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Supply level follows the bench request.
    assign supply_ok_out = supply_req_in;
    // Pulled-up pin is low while either party pulls it.
    assign pin_n_out = !(pin_low_in || pin_oe_in);
    // System clock of 200 ns period, held low while stopped.
    // The 10 ns offset keeps its edges away from the controller's clock edges.
    initial begin
        sys_clk_out = 1'b0;
        #10;
        forever #100 sys_clk_out = clk_stop_in ? 1'b0 : !sys_clk_out;
    end
endmodule

// >>> rsc_reset_ctrl_test.sv
// Self-checking test of the reset source controller.
module rsc_reset_ctrl_test;
    import rsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, sup = 0, pl = 0, cs = 0;
    logic [7:0]  pa = 0;
    logic [31:0] pd = 0, q, prd;
    logic        rdy, err, e, sok, pn, sck, oe, cr, sel, vm, irq, rb, we, od, pu;
    logic [7:0]  lat;
    logic [15:0] fa;
    logic [3:0]  dv;
    int          fails = 0, comparisons = 0;
    rsc_far_side far (.supply_req_in(sup), .pin_low_in(pl), .clk_stop_in(cs), .pin_oe_in(oe),
        .supply_ok_out(sok), .pin_n_out(pn), .sys_clk_out(sck));
    rsc_reset_ctrl #(.POR_DELAY_CYCLES(8), .MCD_TIMEOUT_CYCLES(16)) uut (.clk_in(clk_in),
        .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
        .pwdata_in(pd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
        .supply_ok_in(sok), .reset_pin_n_in(pn), .reset_pin_out(), .reset_pin_oe_out(oe),
        .sys_clk_in(sck), .port_data_in(8'h00), .port_od_in(1'b0), .pullup_req_in(1'b0),
        .port_latch_out(lat), .port_od_out(od), .pullup_en_out(pu), .core_reset_out(cr),
        .ram_write_block_out(rb), .pc_load_out(), .fetch_addr_out(fa), .sysclk_sel_out(sel),
        .wdt_enable_out(we), .wdt_div_out(dv), .vdd_mon_en_out(vm), .irq_out(irq));
    // Free-running 25 MHz clock.
    initial forever #20 clk_in = !clk_in;
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle edge first keeps back-to-back calls apart.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge clk_in) pen <= 1;
        do @(posedge clk_in); while (rdy !== 1'b1 && ++n < 50);
        if (rdy !== 1'b1) fails++;
        q = prd;
        e = err;
        psel <= 0;
        pen <= 0;
    endtask
    // Waits, bounded, until the chip leaves reset.
    task automatic wait_run();
        for (int n = 0; n < 500 && cr !== 1'b0; n++) @(posedge clk_in);
        if (cr !== 1'b0) fails++;
        @(posedge clk_in);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog that cuts a hang short.
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    // Test sequence.
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 0;
        repeat (3) @(posedge clk_in);
        chk({cr, rb, oe, od, pu, lat}, 32'h1FFF);
        sup <= 1;
        wait_run();
        chk({fa, dv, sel, vm, we}, 32'h63);
        chk({cr, rb, od, pu, lat}, 32'h0);
        apb(0, ADDR_RESET_SOURCE, 0);
        chk(q, 32'h2);
        $display("power-on test done");
        pl <= 1;
        repeat (3) @(posedge clk_in);
        chk({cr, rb, od, pu, lat}, 32'hFFF);
        pl <= 0;
        wait_run();
        apb(0, ADDR_RESET_SOURCE, 0);
        chk(q, 32'h1);
        $display("pin reset test done");
        apb(1, ADDR_IRQ_ENABLE, 1);
        repeat (2) @(posedge clk_in);
        chk(irq, 1);
        apb(1, ADDR_IRQ_CLEAR, 1);
        repeat (2) @(posedge clk_in);
        chk(irq, 0);
        apb(0, 8'h20, 0);
        chk(e, 1);
        $display("interrupt test done");
        cs <= 1;
        repeat (20) @(posedge clk_in);
        cs <= 0;
        apb(0, ADDR_RESET_SOURCE, 0);
        chk(q, 32'h4);
        apb(1, ADDR_RESET_SOURCE, 0);
        cs <= 1;
        repeat (20) @(posedge clk_in);
        cs <= 0;
        apb(0, ADDR_CONTROL, 0);
        chk(q, 32'h5);
        apb(0, ADDR_RESET_SOURCE, 0);
        chk(q, 32'h4);
        $display("missing clock test done");
        apb(1, ADDR_RESET_SOURCE, 1);
        repeat (3) @(posedge clk_in);
        chk(oe, 1);
        wait_run();
        apb(0, ADDR_RESET_SOURCE, 0);
        chk(q, 32'h2);
        $display("software power-on test done");
        sup <= 0;
        repeat (3) @(posedge clk_in);
        chk({cr, oe}, 32'h3);
        sup <= 1;
        wait_run();
        apb(0, ADDR_RESET_SOURCE, 0);
        chk(q, 32'h0);
        apb(0, ADDR_IRQ_STATUS, 0);
        chk(q, 32'hE);
        $display("supply drop test done");
        give_verdict();
    end
endmodule
